// file: verilog/irpw_pkg.sv
// Constants, states and the prescale decoder for the IR carrier / PWM generator
// What this block does
// R1: Carrier frequency is timer clock over two times (1+carrier preset) times prescale.
// R2: High phase lasts prescale times (1+high preset) timer clock periods.
// R3: Low phase lasts prescale times (1+low preset) timer clock periods.
// R4: Carrier counter counts down over 8 bits, with its own clock select.
// R5: Low-time-only clear and carrier-in-low set: carrier drives the pin in low phase.
// R6: Low-time-only and carrier-in-low clear: no carrier in low phase, plain PWM from the two times.
// R7: After enable falls, keep transmitting until the next high-phase underflow (low underflow in low-time-only mode), then stop.
// R8: Low-time-only set: high timer ignored; with carrier-in-low clear, output formed from the low timer only.
// R9: High-pulse timer underflow raises its own interrupt.
// R10: Low-pulse timer underflow raises its own interrupt.
// R11: Outside low-time-only mode, each timer reloads on underflow and hands over, phases alternating while enabled.
// R12: Disabled and not draining, the pin is held low.
package irpw_pkg;

   localparam int COUNT_W = 8;
   localparam int SEL_W = 2;
   localparam int PRE_W = 3;

   // Prescale ratios, minus one, for select codes 0..3 (ratios 1, 2, 4, 8)
   localparam logic [PRE_W-1:0] PRE_LAST_SEL0 = 3'h0;
   localparam logic [PRE_W-1:0] PRE_LAST_SEL1 = 3'h1;
   localparam logic [PRE_W-1:0] PRE_LAST_SEL2 = 3'h3;
   localparam logic [PRE_W-1:0] PRE_LAST_SEL3 = 3'h7;

   localparam logic [COUNT_W-1:0] COUNT_RST = 8'h00;
   localparam logic [PRE_W-1:0] PRE_CNT_RST = 3'h0;
   localparam logic CARRIER_START_LEVEL = 1'b1;
   localparam logic PIN_IDLE_LEVEL = 1'b0;

   typedef enum logic [1:0] {
      IRPW_IDLE = 2'b00,
      IRPW_RUN = 2'b01,
      IRPW_DRAIN = 2'b10
   } irpw_state_t;

   function automatic logic [PRE_W-1:0] irpw_pre_last(input logic [SEL_W-1:0] sel);
      logic [PRE_W-1:0] last;
      unique case (sel)
         2'h0: last = PRE_LAST_SEL0;
         2'h1: last = PRE_LAST_SEL1;
         2'h2: last = PRE_LAST_SEL2;
         2'h3: last = PRE_LAST_SEL3;
      endcase
      return last;
   endfunction

endpackage

// file: verilog/irpw_tick_gen.sv
// Prescaler that turns the timer base clock into a selectable tick
`timescale 1ns/100ps
module irpw_tick_gen (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_clear,
   input wire logic [irpw_pkg::SEL_W-1:0] i_select,
   output logic o_tick
);

   logic [irpw_pkg::PRE_W-1:0] cnt_reg;
   logic [irpw_pkg::PRE_W-1:0] last;

   assign last = irpw_pkg::irpw_pre_last(i_select);

   // A select change mid-count takes effect at once: the running count wraps at the new ratio's last value
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         cnt_reg <= irpw_pkg::PRE_CNT_RST;
         o_tick <= 1'b0;
      end else if (i_clear) begin
         // Restart one count in, so the first tick is used a full ratio after the clear
         cnt_reg <= (last == irpw_pkg::PRE_CNT_RST) ? irpw_pkg::PRE_CNT_RST : 3'h1;
         o_tick <= (last == irpw_pkg::PRE_CNT_RST);
      end else if (cnt_reg >= last) begin
         cnt_reg <= irpw_pkg::PRE_CNT_RST;
         o_tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
         o_tick <= 1'b0;
      end
   end

   property p_tick_period;
      @(posedge i_ref_clk) disable iff (!i_reset_n || i_clear)
      o_tick && i_select == 2'h1 && $past(i_select) == 2'h1 |=> !o_tick ##1 o_tick;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("prescale by two broken"); // see R2

endmodule // irpw_tick_gen

// file: verilog/irpw_top.sv
// IR carrier and PWM waveform generator driving one output pin
`timescale 1ns/100ps
module irpw_top (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_ir_function_enable,
   input wire logic i_low_time_only_select,
   input wire logic i_carrier_in_low_phase_enable,
   input wire logic [irpw_pkg::COUNT_W-1:0] i_carrier_counter_preset,
   input wire logic [irpw_pkg::COUNT_W-1:0] i_high_pulse_preset,
   input wire logic [irpw_pkg::COUNT_W-1:0] i_low_pulse_preset,
   input wire logic [irpw_pkg::SEL_W-1:0] i_carrier_clock_select,
   input wire logic [irpw_pkg::SEL_W-1:0] i_pulse_timer_clock_select,
   output logic o_ir_output_pin,
   output logic o_high_underflow_irq,
   output logic o_low_underflow_irq,
   output logic o_busy
);

   irpw_pkg::irpw_state_t state_reg;
   irpw_pkg::irpw_state_t state_next;
   logic phase_high_reg;
   logic [irpw_pkg::COUNT_W-1:0] pulse_cnt_reg;
   logic [irpw_pkg::COUNT_W-1:0] carrier_cnt_reg;
   logic carrier_level_reg;
   logic low_only_level_reg;
   logic active;
   logic start;
   logic carrier_tick;
   logic pulse_tick;
   logic pulse_uf;
   logic high_uf;
   logic low_uf;
   logic stop;
   logic pin_next;

   assign active = (state_reg != irpw_pkg::IRPW_IDLE);
   assign start = (state_reg == irpw_pkg::IRPW_IDLE) && i_ir_function_enable;
   assign pulse_uf = active && pulse_tick && (pulse_cnt_reg == irpw_pkg::COUNT_RST);
   assign high_uf = pulse_uf && phase_high_reg;
   assign low_uf = pulse_uf && !phase_high_reg;
   // With the high timer ignored there is no high underflow, so a drain ends on a low one
   assign stop = (state_reg == irpw_pkg::IRPW_DRAIN) &&
                 (high_uf || (low_uf && i_low_time_only_select)); // see R7

   // Both prescalers restart with the function so the first phase is full length
   irpw_tick_gen u_carrier_tick (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_clear(start),
      .i_select(i_carrier_clock_select), // see R4
      .o_tick(carrier_tick)
   );

   irpw_tick_gen u_pulse_tick (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_clear(start),
      .i_select(i_pulse_timer_clock_select),
      .o_tick(pulse_tick)
   );

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         irpw_pkg::IRPW_IDLE: begin
            if (i_ir_function_enable) begin
               state_next = irpw_pkg::IRPW_RUN;
            end
         end
         irpw_pkg::IRPW_RUN: begin
            if (!i_ir_function_enable) begin
               state_next = irpw_pkg::IRPW_DRAIN; // see R7
            end
         end
         irpw_pkg::IRPW_DRAIN: begin
            if (stop) begin
               state_next = irpw_pkg::IRPW_IDLE; // see R7
            end else if (i_ir_function_enable) begin
               state_next = irpw_pkg::IRPW_RUN;
            end
         end
         default: state_next = irpw_pkg::IRPW_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         state_reg <= irpw_pkg::IRPW_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Carrier: half period is (1+preset) ticks, so a full period is twice that
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         carrier_cnt_reg <= irpw_pkg::COUNT_RST;
         carrier_level_reg <= irpw_pkg::CARRIER_START_LEVEL;
      end else if (start) begin
         carrier_cnt_reg <= i_carrier_counter_preset;
         carrier_level_reg <= irpw_pkg::CARRIER_START_LEVEL;
      end else if (active && carrier_tick) begin
         if (carrier_cnt_reg == irpw_pkg::COUNT_RST) begin
            carrier_cnt_reg <= i_carrier_counter_preset; // see R1
            carrier_level_reg <= !carrier_level_reg; // see R1
         end else begin
            carrier_cnt_reg <= carrier_cnt_reg - 8'h01; // see R4
         end
      end
   end

   // Pulse timers share one down counter; the phase says which preset it holds
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         pulse_cnt_reg <= irpw_pkg::COUNT_RST;
         phase_high_reg <= 1'b0;
         low_only_level_reg <= 1'b0;
      end else if (start) begin
         phase_high_reg <= !i_low_time_only_select; // see R8
         pulse_cnt_reg <= i_low_time_only_select ? i_low_pulse_preset : i_high_pulse_preset;
         low_only_level_reg <= 1'b1;
      end else if (pulse_uf) begin
         if (phase_high_reg || i_low_time_only_select) begin
            phase_high_reg <= 1'b0;
            pulse_cnt_reg <= i_low_pulse_preset; // see R3, R11
         end else begin
            phase_high_reg <= 1'b1;
            pulse_cnt_reg <= i_high_pulse_preset; // see R2, R11
         end
         if (!phase_high_reg) begin
            low_only_level_reg <= !low_only_level_reg; // see R8
         end
      end else if (active && pulse_tick) begin
         pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
      end
   end

   always_comb begin
      pin_next = irpw_pkg::PIN_IDLE_LEVEL; // see R12
      if (active && !stop) begin
         if (phase_high_reg) begin
            pin_next = 1'b1;
         end else if (i_carrier_in_low_phase_enable) begin
            pin_next = carrier_level_reg; // see R5
         end else if (i_low_time_only_select) begin
            pin_next = low_only_level_reg; // see R8
         end else begin
            pin_next = 1'b0; // see R6
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         o_ir_output_pin <= irpw_pkg::PIN_IDLE_LEVEL;
         o_high_underflow_irq <= 1'b0;
         o_low_underflow_irq <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         o_ir_output_pin <= pin_next;
         o_high_underflow_irq <= high_uf; // see R9
         o_low_underflow_irq <= low_uf; // see R10
         o_busy <= (state_next != irpw_pkg::IRPW_IDLE);
      end
   end

   property p_idle_low;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      state_reg == irpw_pkg::IRPW_IDLE |=> !o_ir_output_pin;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("pin not low while idle"); // see R12

   property p_high_out;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      state_reg == irpw_pkg::IRPW_RUN && phase_high_reg |=> o_ir_output_pin;
   endproperty
   a_high_out: assert property (p_high_out) else $error("pin low in high phase"); // see R2

   property p_plain_pwm;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      state_reg == irpw_pkg::IRPW_RUN && !phase_high_reg && !i_carrier_in_low_phase_enable
      && !i_low_time_only_select |=> !o_ir_output_pin;
   endproperty
   a_plain_pwm: assert property (p_plain_pwm) else $error("carrier leaked into PWM"); // see R6

   property p_carrier_low;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      state_reg == irpw_pkg::IRPW_RUN && !phase_high_reg && i_carrier_in_low_phase_enable
      |=> o_ir_output_pin == $past(carrier_level_reg);
   endproperty
   a_carrier_low: assert property (p_carrier_low) else $error("carrier missing in low"); // see R5

   property p_high_irq;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      high_uf |=> o_high_underflow_irq ##1 !o_high_underflow_irq;
   endproperty
   a_high_irq: assert property (p_high_irq) else $error("high underflow irq wrong"); // see R9

   property p_low_irq;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      low_uf |=> o_low_underflow_irq ##1 o_low_underflow_irq == $past(low_uf);
   endproperty
   a_low_irq: assert property (p_low_irq) else $error("low underflow irq wrong"); // see R10

   property p_drain;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      state_reg == irpw_pkg::IRPW_RUN && !i_ir_function_enable
      |=> state_reg == irpw_pkg::IRPW_DRAIN && o_busy;
   endproperty
   a_drain: assert property (p_drain) else $error("stopped without draining"); // see R7

   property p_drain_stop;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      state_reg == irpw_pkg::IRPW_DRAIN && high_uf
      |=> state_reg == irpw_pkg::IRPW_IDLE && !o_ir_output_pin && !o_busy;
   endproperty
   a_drain_stop: assert property (p_drain_stop) else $error("drain did not end"); // see R7

   property p_carrier_reload;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      active && carrier_tick && carrier_cnt_reg == 8'h00
      |=> carrier_cnt_reg == $past(i_carrier_counter_preset)
      && carrier_level_reg != $past(carrier_level_reg);
   endproperty
   a_carrier_reload: assert property (p_carrier_reload) else $error("carrier reload bad"); // see R1

   property p_carrier_down;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      active && !start && carrier_tick && carrier_cnt_reg != 8'h00
      |=> carrier_cnt_reg == $past(carrier_cnt_reg) - 8'h01;
   endproperty
   a_carrier_down: assert property (p_carrier_down) else $error("carrier count bad"); // see R4

   property p_handover;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      low_uf && !i_low_time_only_select
      |=> phase_high_reg && pulse_cnt_reg == $past(i_high_pulse_preset);
   endproperty
   a_handover: assert property (p_handover) else $error("low to high handover bad"); // see R11

   property p_high_to_low;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      high_uf |=> !phase_high_reg && pulse_cnt_reg == $past(i_low_pulse_preset);
   endproperty
   a_high_to_low: assert property (p_high_to_low) else $error("high to low bad"); // see R3

   property p_low_only_stay_low;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      active && i_low_time_only_select && !phase_high_reg |=> !phase_high_reg;
   endproperty
   a_low_only_stay_low: assert property (p_low_only_stay_low) else $error("high timer used"); // see R8

endmodule // irpw_top

// file: bench/irpw_ir_load.sv
// Load on the IR pin: measures each completed high and low run in clock cycles
`timescale 1ns/100ps
module irpw_ir_load (
   input wire logic i_ref_clk,
   input wire logic i_ir_output_pin,
   output int o_high_len,
   output int o_low_len
);
   logic last_reg = 1'b0;
   int run_reg = 0;
   // A run is only reported once it ends, so a partial run never shows up
   always @(posedge i_ref_clk) begin
      last_reg <= i_ir_output_pin;
      if (i_ir_output_pin === last_reg) begin
         run_reg <= run_reg + 1;
      end else begin
         run_reg <= 1;
         if (last_reg) begin
            o_high_len <= run_reg;
         end else begin
            o_low_len <= run_reg;
         end
      end
   end
endmodule // irpw_ir_load

// file: bench/test_irpw_top.sv
// Self-checking bench for the IR carrier and PWM generator
`timescale 1ns/100ps
module test_irpw_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b0;
   logic low_only = 1'b0;
   logic carrier_low = 1'b0;
   logic [irpw_pkg::COUNT_W-1:0] cp = 8'h00;
   logic [irpw_pkg::COUNT_W-1:0] hp = 8'h00;
   logic [irpw_pkg::COUNT_W-1:0] lp = 8'h00;
   logic [irpw_pkg::SEL_W-1:0] cs = 2'h0;
   logic [irpw_pkg::SEL_W-1:0] ps = 2'h0;
   logic pin, hirq, lirq, busy;
   logic act;
   int hlen, llen, gap, n_hi;
   int n_mismatch = 0;
   int n_tests = 0;

   always #25 clk = ~clk;
   always @(posedge clk) if (hirq === 1'b1) n_hi++;

   irpw_top u_irpw_top (.i_ref_clk(clk), .i_reset_n(rst_n), .i_ir_function_enable(en),
      .i_low_time_only_select(low_only), .i_carrier_in_low_phase_enable(carrier_low),
      .i_carrier_counter_preset(cp), .i_high_pulse_preset(hp), .i_low_pulse_preset(lp),
      .i_carrier_clock_select(cs), .i_pulse_timer_clock_select(ps), .o_ir_output_pin(pin),
      .o_high_underflow_irq(hirq), .o_low_underflow_irq(lirq), .o_busy(busy));
   irpw_ir_load u_irpw_ir_load (.i_ref_clk(clk), .i_ir_output_pin(pin),
      .o_high_len(hlen), .o_low_len(llen));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %0d seen %0d", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic step();
      @(posedge clk);
      #1;
   endtask

   // Bounded wait for one interrupt pulse; cyc is the number of cycles waited
   task automatic wait_irq(input logic hi, output int cyc);
      cyc = 0;
      do begin
         step();
         cyc++;
      end while (((hi ? hirq : lirq) !== 1'b1) && cyc < 3000);
      if (cyc >= 3000) begin
         n_mismatch++;
         end_of_test();
      end
   endtask

   // Reset for four cycles, load the new setup as reset releases, check idle, then enable
   task automatic start(input logic l, input logic h, input logic [1:0] c_sel,
                        input logic [1:0] p_sel, input logic [7:0] c, input logic [7:0] hi,
                        input logic [7:0] lo);
      rst_n = 1'b0;
      en = 1'b0;
      repeat (4) step();
      low_only = l;
      carrier_low = h;
      cs = c_sel;
      ps = p_sel;
      cp = c;
      hp = hi;
      lp = lo;
      rst_n = 1'b1;
      step();
      check("pin after reset", pin, 1'b0);
      check("busy after reset", busy, 1'b0);
      en = 1'b1;
      n_hi = 0;
   endtask

   initial begin
      // Two-cycle phases (presets of one), back to back
      start(0, 0, 2'h0, 2'h0, 8'h00, 8'h01, 8'h01);
      wait_irq(1, gap);
      check("pin at high irq", pin, 1'b1);
      wait_irq(0, gap);
      check("low phase", gap, 2);
      check("pin at low irq", pin, 1'b0);
      step();
      check("low irq width", lirq, 1'b0);
      wait_irq(1, gap);
      check("high phase", gap, 1);
      // Every pulse prescale code, plain PWM
      for (int s = 0; s < 4; s++) begin
         start(0, 0, 2'h0, 2'(s), 8'h00, 8'h02, 8'h03);
         wait_irq(1, gap);
         wait_irq(0, gap);
         check("low phase", gap, (1 << s) * 4);
         wait_irq(1, gap);
         check("high phase", gap, (1 << s) * 3);
         check("pin high run", hlen, (1 << s) * 3);
         check("pin low run", llen, (1 << s) * 4);
      end
      // Carrier in the low phase, every carrier prescale code
      for (int s = 0; s < 4; s++) begin
         start(0, 1, 2'(s), 2'h0, 8'h02, 8'h00, 8'hc8);
         wait_irq(1, gap);
         repeat (150) step();
         check("carrier high", hlen, (1 << s) * 3);
         check("carrier low", llen, (1 << s) * 3);
      end
      // Enable dropped in the low phase: runs on to the next high underflow
      start(0, 0, 2'h0, 2'h0, 8'h00, 8'h03, 8'h03);
      wait_irq(1, gap);
      en = 1'b0;
      wait_irq(0, gap);
      check("drain low phase", gap, 4);
      check("busy in drain", busy, 1'b1);
      wait_irq(1, gap);
      check("drain high phase", gap, 4);
      step();
      check("busy after drain", busy, 1'b0);
      act = 1'b0;
      repeat (20) begin
         step();
         act = act | pin | hirq | lirq | busy;
      end
      check("idle activity", act, 1'b0);
      // Low timer only: level toggles at each low underflow
      start(1, 0, 2'h0, 2'h1, 8'h00, 8'h00, 8'h04);
      wait_irq(0, gap);
      wait_irq(0, gap);
      check("low-only period", gap, 10);
      wait_irq(0, gap);
      check("low-only high run", hlen, 10);
      check("low-only low run", llen, 10);
      check("high irqs", n_hi, 0);
      end_of_test();
   end
endmodule // test_irpw_top
